/* File: logic/ppoc_pkg.sv */
// Constants and types for the port power and overcurrent control block
// Operation
// - One two-way pin per port both switches power and senses overcurrent.
// - Two modes: ganged with one shared pin, individual with one pin each.
// - Ganged mode comes only from a configuration input loaded by management.
// - In ganged mode the shared pin controls and senses every port.
// - In ganged mode a shared-pin overcurrent flags all ports together.
// - After reset without configuration the block runs in individual mode.
// - Power off: drive the pin low and switch its pull-up off.
// - Power on: release the pin, pull-up on, open-drain reading high.
// - While enabled the pin is sampled continuously; low may mean overcurrent.
// - Unbroken low samples for the whole single-pulse width report overcurrent.
// - Two separate low groups inside the double-pulse window report overcurrent.
// - The sense input is filtered so brief transients cause no detection; the filter here drops only one-cycle pulses.
// - Each port can indicate a high-current charging supply, per configuration.
// - Single-pulse width is a 4-bit code, 1 ms steps, 0 to 5 ms.
// - Double-pulse window is an 8-bit count of ms, default 20 ms.
// - Overcurrent ignored for 8-bit lockout ms after power on, default 10 ms.
package ppoc_pkg;

    localparam int NUM_PORTS = 6;
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_TIME_US;

    localparam int WIDTH_CODE_W = 4;
    localparam int TIMER_W = 8;
    localparam logic [3:0] WIDTH_CODE_MAX = 4'h5;
    localparam logic [3:0] RUN_SATURATE = 4'h6;
    localparam logic [7:0] WINDOW_DEFAULT = 8'h14;
    localparam logic [7:0] LOCKOUT_DEFAULT = 8'h0A;

    // Idle level of a released pin held up by its pull-up
    localparam logic PIN_IDLE_LEVEL = 1'b1;
    localparam logic PIN_DRIVE_LEVEL = 1'b0;

    typedef enum logic [1:0] {
        DP_IDLE = 2'b00,
        DP_FIRST = 2'b01,
        DP_GAP = 2'b10
    } ppoc_dp_state_type;

endpackage : ppoc_pkg

/* File: logic/ppoc_port_power_ctrl.sv */
// Port power switching and overcurrent detection over shared power/sense pins
`timescale 1ns/1ps
`default_nettype none
module ppoc_port_power_ctrl #(
    parameter int NPORTS = ppoc_pkg::NUM_PORTS,
    parameter int TICK_COUNT = ppoc_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration from management or one-time storage
    input wire logic cfgGanged,
    input wire logic [ppoc_pkg::WIDTH_CODE_W-1:0] cfgMinWidth,
    input wire logic [ppoc_pkg::TIMER_W-1:0] cfgDoubleWindow,
    input wire logic [ppoc_pkg::TIMER_W-1:0] cfgLockout,
    input wire logic [NPORTS-1:0] cfgChargeSupply,
    // Hub port power requests and flag clears
    input wire logic [NPORTS-1:0] portPowerOn,
    input wire logic [NPORTS-1:0] overcurrentClear,
    // Per-port power/sense pins
    input wire logic [NPORTS-1:0] portPinIn,
    output logic [NPORTS-1:0] portPinOut,
    output logic [NPORTS-1:0] portPinOe,
    output logic [NPORTS-1:0] portPullUpEn,
    // Shared power/sense pin for ganged mode
    input wire logic sharedPinIn,
    output logic sharedPinOut,
    output logic sharedPinOe,
    output logic sharedPullUpEn,
    // Status
    output logic gangedActive,
    output logic [NPORTS-1:0] overcurrentFlag,
    output logic [NPORTS-1:0] chargeIndicate
);
    import ppoc_pkg::*;

    localparam int NCHAN = NPORTS + 1;
    localparam int SHARED = NPORTS;
    localparam int TICK_W = (TICK_COUNT > 1) ? $clog2(TICK_COUNT) : 1;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_COUNT - 1);

    generate
        if (NPORTS < 1 || NPORTS > 15) begin : gBadPorts
            $error("ppoc_port_power_ctrl: NPORTS must be 1 to 15");
        end
        if (TICK_COUNT < 1) begin : gBadTick
            $error("ppoc_port_power_ctrl: TICK_COUNT must be at least 1");
        end
        // Run counter must outgrow the widest width code without wrapping
        if (RUN_SATURATE <= WIDTH_CODE_MAX) begin : gBadSaturate
            $error("ppoc_port_power_ctrl: run limit must exceed the widest width code");
        end
        if (int'(RUN_SATURATE) >= (1 << WIDTH_CODE_W)) begin : gBadRunWidth
            $error("ppoc_port_power_ctrl: run limit does not fit the width code");
        end
    endgenerate

    // ---------------- Millisecond tick ----------------
    // One shared grid for all channels; a run may start anywhere inside a tick,
    // so every count below except a zero width code carries a one-tick margin
    logic [TICK_W-1:0] tickCnt;
    logic [TICK_W-1:0] next_tickCnt;
    logic msTick;
    logic next_msTick;

    always_comb begin
        next_tickCnt = tickCnt + TICK_W'(1);
        next_msTick = 1'b0;
        if (tickCnt == TICK_LAST) begin
            next_tickCnt = '0;
            next_msTick = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tickCnt <= '0;
            msTick <= 1'b0;
        end else begin
            tickCnt <= next_tickCnt;
            msTick <= next_msTick;
        end
    end

    // ---------------- Mode and power routing ----------------
    logic [NPORTS-1:0] portOnEff;
    logic sharedOnEff;
    logic [NCHAN-1:0] chanOn;
    logic [NCHAN-1:0] chanHigh;
    logic [NCHAN-1:0] chanDetect;
    logic [WIDTH_CODE_W-1:0] widthClamped;
    logic [WIDTH_CODE_W-1:0] runTarget;

    always_comb begin
        // Ganged: port pins idle, shared pin carries every port
        if (gangedActive) begin
            portOnEff = '0;
            sharedOnEff = |portPowerOn;
        end else begin
            portOnEff = portPowerOn;
            sharedOnEff = 1'b0;
        end
        chanOn = {sharedOnEff, portOnEff};
        // Codes above 5 ms are not defined; hold them at the top code
        if (cfgMinWidth > WIDTH_CODE_MAX) begin
            widthClamped = WIDTH_CODE_MAX;
        end else begin
            widthClamped = cfgMinWidth;
        end
        // One extra tick so a run never falls short of the width
        if (widthClamped == '0) begin
            runTarget = '0;
        end else begin
            runTarget = widthClamped + WIDTH_CODE_W'(1);
        end
    end

    ppoc_sense_sync #(
        .WIDTH(NCHAN)
    ) uSenseSync (
        .clk(clk),
        .rst(rst),
        .pinIn({sharedPinIn, portPinIn}),
        .level(chanHigh)
    );

    // ---------------- Per-channel detectors ----------------
    genvar g;
    generate
        for (g = 0; g < NCHAN; g++) begin : gChan
            logic prevOn;
            logic next_prevOn;
            logic [TIMER_W:0] lockCnt;
            logic [TIMER_W:0] next_lockCnt;
            logic [WIDTH_CODE_W-1:0] runCnt;
            logic [WIDTH_CODE_W-1:0] next_runCnt;
            ppoc_dp_state_type dpState;
            ppoc_dp_state_type next_dpState;
            logic [TIMER_W:0] winCnt;
            logic [TIMER_W:0] next_winCnt;
            logic detect;
            logic next_detect;
            logic low;
            logic singleHit;
            logic doubleHit;

            always_comb begin
                next_prevOn = prevOn;
                next_lockCnt = lockCnt;
                next_runCnt = runCnt;
                next_dpState = dpState;
                next_winCnt = winCnt;
                next_detect = 1'b0;
                low = ~chanHigh[g];
                singleHit = 1'b0;
                doubleHit = 1'b0;
                if (!chanOn[g]) begin
                    // Sensing only means something while powered
                    next_prevOn = 1'b0;
                    next_lockCnt = '0;
                    next_runCnt = '0;
                    next_dpState = DP_IDLE;
                    next_winCnt = '0;
                end else if (!prevOn) begin
                    next_prevOn = 1'b1;
                    next_lockCnt = {1'b0, cfgLockout} + (TIMER_W+1)'(1);
                    next_runCnt = '0;
                    next_dpState = DP_IDLE;
                    next_winCnt = '0;
                end else if (lockCnt != '0) begin
                    // Pin ramps slowly after turn-on; ignore it meanwhile
                    // A zero setting still hides the pin for up to one tick
                    if (msTick) begin
                        next_lockCnt = lockCnt - (TIMER_W+1)'(1);
                    end
                end else begin
                    // Single pulse: unbroken low run counted in ticks
                    if (low) begin
                        if (msTick && runCnt != RUN_SATURATE) begin
                            next_runCnt = runCnt + WIDTH_CODE_W'(1);
                        end
                        singleHit = (runCnt >= runTarget);
                    end else begin
                        next_runCnt = '0;
                    end
                    // Double pulse: low group, high gap, then low again inside the window
                    unique case (dpState)
                        DP_IDLE: begin
                            if (low) begin
                                next_dpState = DP_FIRST;
                                next_winCnt = {1'b0, cfgDoubleWindow} + (TIMER_W+1)'(1);
                            end
                        end
                        DP_FIRST: begin
                            if (!low) begin
                                next_dpState = DP_GAP;
                            end
                        end
                        DP_GAP: begin
                            if (low) begin
                                doubleHit = 1'b1;
                            end
                        end
                        default: begin
                            next_dpState = DP_IDLE;
                        end
                    endcase
                    // Window rolls off the first group when it expires
                    // A zero window still spans one tick; it is never meant to be used
                    if (dpState != DP_IDLE && msTick) begin
                        if (winCnt <= (TIMER_W+1)'(1)) begin
                            next_winCnt = '0;
                            next_dpState = DP_IDLE;
                        end else begin
                            next_winCnt = winCnt - (TIMER_W+1)'(1);
                        end
                    end
                    if (singleHit || doubleHit) begin
                        next_detect = 1'b1;
                        next_runCnt = '0;
                        next_dpState = DP_IDLE;
                        next_winCnt = '0;
                    end
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    prevOn <= 1'b0;
                    lockCnt <= '0;
                    runCnt <= '0;
                    dpState <= DP_IDLE;
                    winCnt <= '0;
                    detect <= 1'b0;
                end else begin
                    prevOn <= next_prevOn;
                    lockCnt <= next_lockCnt;
                    runCnt <= next_runCnt;
                    dpState <= next_dpState;
                    winCnt <= next_winCnt;
                    detect <= next_detect;
                end
            end

            assign chanDetect[g] = detect;
        end
    endgenerate

    // ---------------- Pins, flags and status ----------------
    logic [NPORTS-1:0] next_portPinOe;
    logic [NPORTS-1:0] next_portPullUpEn;
    logic next_sharedPinOe;
    logic next_sharedPullUpEn;
    logic next_gangedActive;
    logic [NPORTS-1:0] next_overcurrentFlag;
    logic [NPORTS-1:0] next_chargeIndicate;
    logic [NPORTS-1:0] detectPerPort;

    always_comb begin
        // Pins follow the mode one edge after it is registered
        next_gangedActive = cfgGanged;
        // Off: drive low, pull-up off; on: release and pull up
        next_portPinOe = ~portOnEff;
        next_portPullUpEn = portOnEff;
        next_sharedPinOe = gangedActive & ~sharedOnEff;
        next_sharedPullUpEn = sharedOnEff;
        if (gangedActive) begin
            // One shared detection stands for every port
            detectPerPort = {NPORTS{chanDetect[SHARED]}};
        end else begin
            detectPerPort = chanDetect[NPORTS-1:0];
        end
        // A detection in the clear cycle still leaves the flag set
        next_overcurrentFlag = (overcurrentFlag & ~overcurrentClear) | detectPerPort;
        next_chargeIndicate = cfgChargeSupply & portPowerOn;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gangedActive <= 1'b0;
            portPinOut <= {NPORTS{PIN_DRIVE_LEVEL}};
            portPinOe <= {NPORTS{1'b1}};
            portPullUpEn <= '0;
            sharedPinOut <= PIN_DRIVE_LEVEL;
            sharedPinOe <= 1'b0;
            sharedPullUpEn <= 1'b0;
            overcurrentFlag <= '0;
            chargeIndicate <= '0;
        end else begin
            gangedActive <= next_gangedActive;
            portPinOut <= {NPORTS{PIN_DRIVE_LEVEL}};
            portPinOe <= next_portPinOe;
            portPullUpEn <= next_portPullUpEn;
            sharedPinOut <= PIN_DRIVE_LEVEL;
            sharedPinOe <= next_sharedPinOe;
            sharedPullUpEn <= next_sharedPullUpEn;
            overcurrentFlag <= next_overcurrentFlag;
            chargeIndicate <= next_chargeIndicate;
        end
    end

endmodule // ppoc_port_power_ctrl
`default_nettype wire

/* File: logic/ppoc_sense_sync.sv */
// Three-stage synchroniser and agreement filter for the sense pins
`timescale 1ns/1ps
`default_nettype none
module ppoc_sense_sync #(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw pin levels
    input wire logic [WIDTH-1:0] pinIn,
    // Filtered levels
    output logic [WIDTH-1:0] level
);
    import ppoc_pkg::*;

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    generate
        if (WIDTH < 1) begin : gBadWidth
            $error("ppoc_sense_sync: WIDTH must be at least 1");
        end
    endgenerate

    // A change counts only once stages two and three agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level[i];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= {WIDTH{PIN_IDLE_LEVEL}};
            stage2 <= {WIDTH{PIN_IDLE_LEVEL}};
            stage3 <= {WIDTH{PIN_IDLE_LEVEL}};
            level <= {WIDTH{PIN_IDLE_LEVEL}};
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= next_level;
        end
    end

endmodule // ppoc_sense_sync
`default_nettype wire

/* File: test/ppoc_port_power_ctrl_sva.sv */
// Concurrent checks on the ports of the port power and overcurrent block
`timescale 1ns/1ps
`default_nettype none
module ppoc_port_power_ctrl_sva #(
    parameter int NPORTS = 6,
    parameter int TICK_COUNT = 25000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration and requests
    input wire logic cfgGanged,
    input wire logic [NPORTS-1:0] cfgChargeSupply,
    input wire logic [NPORTS-1:0] portPowerOn,
    input wire logic [NPORTS-1:0] overcurrentClear,
    // Pins and status
    input wire logic [NPORTS-1:0] portPinOut,
    input wire logic [NPORTS-1:0] portPinOe,
    input wire logic [NPORTS-1:0] portPullUpEn,
    input wire logic sharedPinOut,
    input wire logic sharedPinOe,
    input wire logic sharedPullUpEn,
    input wire logic gangedActive,
    input wire logic [NPORTS-1:0] overcurrentFlag,
    input wire logic [NPORTS-1:0] chargeIndicate
);
    logic [1:0] age;
    logic [1:0] next_age;
    // Past values are meaningful only a few edges after reset
    always_comb next_age = (age == 2'h3) ? age : age + 2'h1;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) age <= 2'h0;
        else age <= next_age;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_flagHeld;
        overcurrentFlag[0] && !overcurrentClear[0] && portPowerOn[0] && !gangedActive;
    endsequence
    sequence s_powerUp;
        $rose(portPowerOn[0]) && !gangedActive && !$past(gangedActive);
    endsequence
    a_mode_follow: assert property (age == 2'h3 |-> gangedActive == $past(cfgGanged))
        else $error("mode does not follow configuration");
    a_off_drive_low: assert property (age == 2'h3 && !$past(gangedActive)
        |-> portPinOe == ~$past(portPowerOn)) else $error("port pin drive wrong");
    a_on_pull_up: assert property (age == 2'h3 && !$past(gangedActive)
        |-> portPullUpEn == $past(portPowerOn)) else $error("port pull-up wrong");
    a_pull_drive_excl: assert property (!(|(portPullUpEn & portPinOe)) && !(|portPinOut)
        && !sharedPinOut && !(sharedPullUpEn && sharedPinOe))
        else $error("pull-up on while driving");
    a_ganged_ports: assert property (age == 2'h3 && $past(gangedActive) |-> &portPinOe)
        else $error("port pins not held in ganged mode");
    a_shared_ctrl: assert property (age == 2'h3 |-> sharedPullUpEn == ($past(gangedActive)
        && |$past(portPowerOn)) && sharedPinOe == ($past(gangedActive)
        && !(|$past(portPowerOn)))) else $error("shared pin control wrong");
    a_charge_track: assert property (age == 2'h3 |-> chargeIndicate
        == $past(cfgChargeSupply & portPowerOn)) else $error("charge flag wrong");
    a_flag_sticky: assert property ((age == 2'h3) ##0 s_flagHeld |=> overcurrentFlag[0])
        else $error("flag dropped without clear");
    a_ganged_all: assert property (gangedActive && $past(gangedActive)
        && $rose(overcurrentFlag[0]) |-> &overcurrentFlag) else $error("ganged flags split");
    a_lockout_quiet: assert property ((age == 2'h3) ##0 s_powerUp
        |=> !$rose(overcurrentFlag[0]) [*8]) else $error("flag inside lockout");
    a_off_clears: assert property (age == 2'h3 && !gangedActive && !$past(gangedActive)
        && !$past(portPowerOn[0]) && !$past(portPowerOn[0], 2) && !$past(portPowerOn[0], 3)
        |-> overcurrentFlag[0] == ($past(overcurrentFlag[0]) && !$past(overcurrentClear[0])))
        else $error("flag set on unpowered port");
endmodule // ppoc_port_power_ctrl_sva
`default_nettype wire

/* File: test/ppoc_switch_model.sv */
// External power switch model resolving the open-drain power and sense pins
`timescale 1ns/1ps
`default_nettype none
module ppoc_switch_model #(
    parameter int W = 1
) (
    // Clock
    input wire logic clk,
    // Device side of the pins
    input wire logic [W-1:0] pinOe,
    input wire logic [W-1:0] pinOut,
    input wire logic [W-1:0] pullUpEn,
    // Fault request from the bench
    input wire logic [W-1:0] faultLow,
    // Resolved pin level
    output logic [W-1:0] level
);
    logic [W-1:0] floatPat = '0;
    // A floating pin must not settle to a friendly constant
    always @(posedge clk) begin
        floatPat <= ~floatPat;
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pinOe[i]) begin
                level[i] = pinOut[i];
            end else if (faultLow[i] && pullUpEn[i]) begin
                level[i] = 1'b0;
            end else begin
                level[i] = pullUpEn[i] ? 1'b1 : floatPat[i];
            end
        end
    end
endmodule // ppoc_switch_model
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the port power and overcurrent control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ppoc_pkg::*;
    localparam int TK = 10;
    localparam int NP = NUM_PORTS;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cfgGanged = 1'b0;
    logic [3:0] cfgMinWidth = 4'h5;
    logic [7:0] cfgDoubleWindow = 8'h03;
    logic [7:0] cfgLockout = 8'h03;
    logic [NP-1:0] cfgChargeSupply = '0;
    logic [NP-1:0] portPowerOn = '0;
    logic [NP-1:0] overcurrentClear = '0;
    logic [NP-1:0] fault = '0;
    logic sharedFault = 1'b0;
    logic [NP-1:0] portPinIn, portPinOut, portPinOe, portPullUpEn, overcurrentFlag, chargeIndicate;
    logic sharedPinIn, sharedPinOut, sharedPinOe, sharedPullUpEn, gangedActive;
    int fail_count = 0;
    int checks_done = 0;
    int modelFlags = 0;
    always #20 clk = ~clk;
    ppoc_port_power_ctrl #(.NPORTS(NP), .TICK_COUNT(TK)) dut (.clk(clk), .rst(rst),
        .cfgGanged(cfgGanged), .cfgMinWidth(cfgMinWidth), .cfgDoubleWindow(cfgDoubleWindow),
        .cfgLockout(cfgLockout), .cfgChargeSupply(cfgChargeSupply), .portPowerOn(portPowerOn),
        .overcurrentClear(overcurrentClear), .portPinIn(portPinIn), .portPinOut(portPinOut),
        .portPinOe(portPinOe), .portPullUpEn(portPullUpEn), .sharedPinIn(sharedPinIn),
        .sharedPinOut(sharedPinOut), .sharedPinOe(sharedPinOe), .sharedPullUpEn(sharedPullUpEn),
        .gangedActive(gangedActive), .overcurrentFlag(overcurrentFlag),
        .chargeIndicate(chargeIndicate));
    ppoc_switch_model #(.W(NP)) portSw (.clk(clk), .pinOe(portPinOe), .pinOut(portPinOut),
        .pullUpEn(portPullUpEn), .faultLow(fault), .level(portPinIn));
    ppoc_switch_model #(.W(1)) sharedSw (.clk(clk), .pinOe(sharedPinOe), .pinOut(sharedPinOut),
        .pullUpEn(sharedPullUpEn), .faultLow(sharedFault), .level(sharedPinIn));
    task automatic cmp(string name, logic [31:0] exp, logic [31:0] got);
        #1;
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    // Holds a fault low on the chosen pins for n cycles
    task automatic low(logic [NP-1:0] m, logic sh, int n);
        @(posedge clk);
        fault <= m;
        sharedFault <= sh;
        cyc(n);
        fault <= '0;
        sharedFault <= 1'b0;
    endtask
    // Flag check after the filter latency, then idle past the double window
    task automatic settle(logic [NP-1:0] m, int hit);
        if (hit != 0) modelFlags = modelFlags | int'(m);
        cyc(12);
        cmp("overcurrentFlag", modelFlags, overcurrentFlag);
        cyc(40);
    endtask
    task automatic clear(logic [NP-1:0] m);
        @(posedge clk);
        overcurrentClear <= m;
        @(posedge clk);
        overcurrentClear <= '0;
        modelFlags = modelFlags & ~int'(m);
        cyc(2);
        cmp("overcurrentFlag", modelFlags, overcurrentFlag);
    endtask
    function automatic int single_hit(int w, int n);
        return (n >= w * TK) ? 1 : 0;
    endfunction
    task automatic end_of_test();
        $display("checks_done %0d fail_count %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        cyc(30000);
        fail_count++;
        $display("unexpected run length: expected end seen timeout");
        end_of_test();
    end
    initial begin
        logic [NP-1:0] m;
        void'($urandom(67));
        cyc(2);
        rst <= 1'b0;
        cyc(2);
        cmp("gangedActive", 0, gangedActive);
        cmp("portPinOe", (1 << NP) - 1, portPinOe);
        repeat (4) begin
            @(posedge clk);
            portPowerOn <= NP'($urandom());
            cfgChargeSupply <= NP'($urandom());
            cyc(2);
            cmp("portPullUpEn", portPowerOn, portPullUpEn);
            cmp("portPinOe", NP'(~portPowerOn), portPinOe);
            cmp("chargeIndicate", cfgChargeSupply & portPowerOn, chargeIndicate);
            cmp("portPinIn", portPowerOn, portPinIn);
        end
        $display("power test done");
        @(posedge clk);
        portPowerOn <= '1;
        cyc(60);
        for (int w = 0; w <= 5; w++) begin
            m = NP'(1) << (w % NP);
            @(posedge clk);
            cfgMinWidth <= 4'(w);
            if (w > 0) begin
                low(m, 1'b0, w * TK - 8);
                settle(m, single_hit(w, w * TK - 8));
            end
            low(m, 1'b0, (w + 2) * TK);
            settle(m, single_hit(w, (w + 2) * TK));
            clear(m);
        end
        $display("single pulse test done");
        m = NP'(2);
        low(m, 1'b0, 15);
        cyc(8);
        low(m, 1'b0, 15);
        settle(m, (24 < 3 * TK) ? 1 : 0);
        clear(m);
        low(m, 1'b0, 15);
        cyc(45);
        low(m, 1'b0, 15);
        settle(m, (61 < 3 * TK) ? 1 : 0);
        low(m, 1'b0, 1);
        settle(m, single_hit(5, 1));
        $display("double pulse test done");
        cfgMinWidth <= 4'h0;
        portPowerOn[0] <= 1'b0;
        cyc(4);
        portPowerOn[0] <= 1'b1;
        low(NP'(1), 1'b0, 20);
        settle(NP'(1), (20 >= 3 * TK) ? 1 : 0);
        low(NP'(1), 1'b0, 20);
        settle(NP'(1), 1);
        clear(NP'(1));
        $display("lockout test done");
        @(posedge clk);
        cfgGanged <= 1'b1;
        cfgMinWidth <= 4'h1;
        cyc(3);
        cmp("gangedActive", 1, gangedActive);
        cmp("portPinOe", (1 << NP) - 1, portPinOe);
        cmp("sharedPullUpEn", 1, sharedPullUpEn);
        cyc(60);
        low('0, 1'b1, 30);
        settle('1, single_hit(1, 30));
        clear('1);
        // Out-of-range width code must act as the widest code
        @(posedge clk);
        cfgMinWidth <= 4'hF;
        low('0, 1'b1, 42);
        settle('1, single_hit(5, 42));
        $display("ganged test done");
        end_of_test();
    end
endmodule // tb
bind ppoc_port_power_ctrl ppoc_port_power_ctrl_sva #(.NPORTS(NPORTS), .TICK_COUNT(TICK_COUNT))
    chk (.clk(clk), .rst(rst), .cfgGanged(cfgGanged), .cfgChargeSupply(cfgChargeSupply),
    .portPowerOn(portPowerOn), .overcurrentClear(overcurrentClear), .portPinOut(portPinOut),
    .portPinOe(portPinOe), .portPullUpEn(portPullUpEn), .sharedPinOut(sharedPinOut),
    .sharedPinOe(sharedPinOe), .sharedPullUpEn(sharedPullUpEn), .gangedActive(gangedActive),
    .overcurrentFlag(overcurrentFlag), .chargeIndicate(chargeIndicate));
`default_nettype wire
